// *** core/pss_pkg.sv ***
`default_nettype none
package pss_pkg;
   // --------------------------------------------------------------
   // register map (byte addresses)
   // --------------------------------------------------------------
   localparam logic [7:0] ADDR_WAKE2 = 8'h14;
   localparam logic [7:0] ADDR_RUN = 8'h18;
   localparam logic [7:0] ADDR_PDOWN1 = 8'h1c;
   localparam logic [7:0] ADDR_PDOWN2 = 8'h20;
   localparam logic [7:0] ADDR_CTRL = 8'h40;
   localparam logic [7:0] ADDR_STAT = 8'h44;
   localparam int NUM_CFG = 4;
   localparam int IDX_RUN = 1;
   localparam int IDX_PDOWN1 = 2;
   // --------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------
   localparam int DWELL_LSB = 16;
   localparam int GATE_BIT = 14;
   localparam int APFM_BIT = 9;
   localparam int CPFM_BIT = 8;
   localparam int IO_BIT = 5;
   localparam int PLL_BIT = 4;
   localparam int ANA_BIT = 1;
   localparam int CORE_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 0;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_PGOOD_LSB = 4;
   // --------------------------------------------------------------
   // types
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RESET = 3'b000,
      ST_ASLEEP = 3'b001,
      ST_WAKE1 = 3'b010,
      ST_WAKE2 = 3'b011,
      ST_AWAKE_WAIT = 3'b100,
      ST_AWAKE = 3'b101,
      ST_PDOWN1 = 3'b110,
      ST_PDOWN2 = 3'b111
   } pss_state_t;
   typedef struct packed {
      logic tileClkGate;
      logic analogPfm;
      logic corePfm;
      logic ioEn;
      logic pllEn;
      logic analogEn;
      logic coreEn;
   } pss_supply_t;
   typedef struct packed {
      logic [4:0] dwell;
      pss_supply_t sup;
   } pss_cfg_t;
   // --------------------------------------------------------------
   // values after reset, fixed state supplies and constants
   // --------------------------------------------------------------
   localparam logic [4:0] DWELL_RST = 5'h10;
   localparam pss_supply_t SUP_WAKE2_RST = 7'h0f;
   localparam pss_supply_t SUP_RUN_RST = 7'h0f;
   localparam pss_supply_t SUP_PDOWN1_RST = 7'h0a;
   localparam pss_supply_t SUP_PDOWN2_RST = 7'h02;
   localparam pss_supply_t SUP_ASLEEP = 7'h02;
   localparam pss_supply_t SUP_WAKE1 = 7'h0a;
   localparam pss_supply_t SUP_OFF = 7'h00;
   localparam logic [31:0] DWELL_ONE = 32'h0000_0001;
endpackage
`default_nettype wire

// *** core/pss_power_state_supply_config.sv ***
// What this block does
// - in second wake stage, outputs follow the second-wake-stage register
// - second wake lasts at least the dwell, then waits for all enabled power good
// - dwell field 20:16 means 2^n cycles, resets to 16
// - in running state, outputs follow the running register; no dwell, 31:15 reserved
// - first power-down lasts exactly the programmed dwell, outputs from its register
// - second power-down lasts the programmed dwell, outputs from its register
// - bit 14 set gates the processor tile clock; resets to 0
// - bit 9 analog buck, bit 8 core buck modulation; 0 PWM, 1 PFM
// - bit 5 enables the I/O supply output in that state
// - bit 4 enables the PLL supply regulator in that state
// - bit 1 is read-only and reads 1: analog buck always enabled here
// - bit 0 enables the core buck; 1 at reset in wake and run, else 0
// - state code: 0 reset,1 asleep,2,3 wake,4 awake-wait,5 awake,6,7 power-down
// - dwell counts cycles of the currently running clock
//
// Design decision made here: register access over APB.
`default_nettype none
module pss_power_state_supply_config (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins from regulators and wake source
   input wire logic [3:0] pgoodPin,
   input wire logic wakePin,
   // regulator and tile clock controls, sequencer state
   output var pss_pkg::pss_supply_t supplyCtl,
   output var pss_pkg::pss_state_t seqState
);
   // --------------------------------------------------------------
   // input synchronisers
   // --------------------------------------------------------------
   // pgood order: {io, pll, analog, core}; wake in bit 4
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic [4:0] sync3_ff;
   logic [4:0] inFilt_ff;
   logic [3:0] pgood;
   logic wakeReq;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
      end
      else
      begin
         sync1_ff <= {wakePin, pgoodPin};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // change counts only once second and third stage agree
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         inFilt_ff <= '0;
      end
      else
      begin
         inFilt_ff <= (~(sync2_ff ^ sync3_ff) & sync3_ff) |
                      ((sync2_ff ^ sync3_ff) & inFilt_ff);
      end
   end

   assign pgood = inFilt_ff[3:0];
   assign wakeReq = inFilt_ff[4];

   // --------------------------------------------------------------
   // apb decode
   // --------------------------------------------------------------
   logic setupPhase;
   logic wrStrobe;
   logic ready_ff;
   logic [31:0] rdata_ff;
   logic slverr_ff;
   logic sleepReq_ff;
   pss_pkg::pss_cfg_t cfg_ff [pss_pkg::NUM_CFG];
   pss_pkg::pss_state_t state_ff;
   pss_pkg::pss_state_t nxt_state;
   logic [7:0] cfgAddr [pss_pkg::NUM_CFG];

   assign cfgAddr[0] = pss_pkg::ADDR_WAKE2;
   assign cfgAddr[1] = pss_pkg::ADDR_RUN;
   assign cfgAddr[2] = pss_pkg::ADDR_PDOWN1;
   assign cfgAddr[3] = pss_pkg::ADDR_PDOWN2;

   // no wait state: pready and prdata come straight from flops loaded in the setup phase
   assign setupPhase = psel & ~penable & ~ready_ff;
   assign wrStrobe = psel & penable & ready_ff & pwrite;

   function automatic logic [31:0] cfgWord(input pss_pkg::pss_cfg_t c);
      logic [31:0] w;
      w = '0;
      w[pss_pkg::DWELL_LSB +: 5] = c.dwell;
      w[pss_pkg::GATE_BIT] = c.sup.tileClkGate;
      w[pss_pkg::APFM_BIT] = c.sup.analogPfm;
      w[pss_pkg::CPFM_BIT] = c.sup.corePfm;
      w[pss_pkg::IO_BIT] = c.sup.ioEn;
      w[pss_pkg::PLL_BIT] = c.sup.pllEn;
      w[pss_pkg::ANA_BIT] = 1'b1;
      w[pss_pkg::CORE_BIT] = c.sup.coreEn;
      return w;
   endfunction

   logic [31:0] rdMux;
   logic hit;

   always_comb
   begin
      rdMux = '0;
      hit = 1'b1;
      case (paddr)
         pss_pkg::ADDR_WAKE2: rdMux = cfgWord(cfg_ff[0]);
         pss_pkg::ADDR_RUN: rdMux = cfgWord(cfg_ff[1]);
         pss_pkg::ADDR_PDOWN1: rdMux = cfgWord(cfg_ff[2]);
         pss_pkg::ADDR_PDOWN2: rdMux = cfgWord(cfg_ff[3]);
         pss_pkg::ADDR_CTRL: rdMux[pss_pkg::CTRL_SLEEP_BIT] = sleepReq_ff;
         pss_pkg::ADDR_STAT:
         begin
            rdMux[pss_pkg::STAT_STATE_LSB +: 3] = state_ff;
            rdMux[pss_pkg::STAT_PGOOD_LSB +: 4] = pgood;
         end
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         ready_ff <= 1'b0;
         rdata_ff <= '0;
         slverr_ff <= 1'b0;
      end
      else
      begin
         ready_ff <= setupPhase;
         rdata_ff <= (setupPhase & ~pwrite) ? rdMux : '0;
         slverr_ff <= setupPhase & ~hit;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         sleepReq_ff <= 1'b0;
      end
      else if (wrStrobe && paddr == pss_pkg::ADDR_CTRL)
      begin
         sleepReq_ff <= pwdata[pss_pkg::CTRL_SLEEP_BIT];
      end
   end

   // --------------------------------------------------------------
   // per-state configuration registers
   // --------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < pss_pkg::NUM_CFG; gi++)
      begin : g_cfg
         // constant so the async reset branch loads no logic
         localparam pss_pkg::pss_supply_t SUP_RST = (gi == 0) ? pss_pkg::SUP_WAKE2_RST :
                                                    (gi == 1) ? pss_pkg::SUP_RUN_RST :
                                                    (gi == 2) ? pss_pkg::SUP_PDOWN1_RST :
                                                    pss_pkg::SUP_PDOWN2_RST;
         always_ff @(posedge mclk or negedge resetn)
         begin
            if (!resetn)
            begin
               cfg_ff[gi].dwell <= (gi == pss_pkg::IDX_RUN) ? 5'h00 :
                                   pss_pkg::DWELL_RST;
               cfg_ff[gi].sup <= SUP_RST;
            end
            else if (wrStrobe && paddr == cfgAddr[gi])
            begin
               // running register keeps no dwell: upper bits reserved
               if (gi != pss_pkg::IDX_RUN)
               begin
                  cfg_ff[gi].dwell <= pwdata[pss_pkg::DWELL_LSB +: 5];
               end
               cfg_ff[gi].sup.tileClkGate <= pwdata[pss_pkg::GATE_BIT];
               cfg_ff[gi].sup.analogPfm <= pwdata[pss_pkg::APFM_BIT];
               cfg_ff[gi].sup.corePfm <= pwdata[pss_pkg::CPFM_BIT];
               cfg_ff[gi].sup.ioEn <= pwdata[pss_pkg::IO_BIT];
               cfg_ff[gi].sup.pllEn <= pwdata[pss_pkg::PLL_BIT];
               cfg_ff[gi].sup.analogEn <= 1'b1;
               cfg_ff[gi].sup.coreEn <= pwdata[pss_pkg::CORE_BIT];
            end
         end
      end
   endgenerate

   // --------------------------------------------------------------
   // active configuration
   // --------------------------------------------------------------
   pss_pkg::pss_supply_t activeSup;
   logic [4:0] activeDwell;

   always_comb
   begin
      activeSup = pss_pkg::SUP_OFF;
      activeDwell = '0;
      case (state_ff)
         pss_pkg::ST_RESET: activeSup = pss_pkg::SUP_OFF;
         pss_pkg::ST_ASLEEP: activeSup = pss_pkg::SUP_ASLEEP;
         pss_pkg::ST_WAKE1: activeSup = pss_pkg::SUP_WAKE1;
         pss_pkg::ST_WAKE2:
         begin
            activeSup = cfg_ff[0].sup;
            activeDwell = cfg_ff[0].dwell;
         end
         pss_pkg::ST_AWAKE_WAIT: activeSup = cfg_ff[1].sup;
         pss_pkg::ST_AWAKE: activeSup = cfg_ff[1].sup;
         pss_pkg::ST_PDOWN1:
         begin
            activeSup = cfg_ff[2].sup;
            activeDwell = cfg_ff[2].dwell;
         end
         pss_pkg::ST_PDOWN2:
         begin
            activeSup = cfg_ff[3].sup;
            activeDwell = cfg_ff[3].dwell;
         end
         default: activeSup = pss_pkg::SUP_OFF;
      endcase
   end

   // --------------------------------------------------------------
   // dwell counter
   // --------------------------------------------------------------
   // only one clock here, so the running clock is mclk; a slow clock
   // just makes each counted cycle longer
   logic [31:0] dwellCnt_ff;
   logic [31:0] dwellLast;
   logic dwellDone;
   logic dwellExact;
   logic allGood;
   logic [3:0] enMask;

   assign dwellLast = (pss_pkg::DWELL_ONE << activeDwell) - pss_pkg::DWELL_ONE;
   assign dwellDone = dwellCnt_ff >= dwellLast;
   assign dwellExact = dwellCnt_ff == dwellLast;
   assign enMask = {activeSup.ioEn, activeSup.pllEn, activeSup.analogEn,
                    activeSup.coreEn};
   assign allGood = (pgood & enMask) == enMask;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         dwellCnt_ff <= '0;
      end
      else if (nxt_state != state_ff)
      begin
         dwellCnt_ff <= '0;
      end
      else if (!dwellDone)
      begin
         dwellCnt_ff <= dwellCnt_ff + pss_pkg::DWELL_ONE;
      end
   end

   // --------------------------------------------------------------
   // sequencer
   // --------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         pss_pkg::ST_RESET: nxt_state = pss_pkg::ST_ASLEEP;
         pss_pkg::ST_ASLEEP:
         begin
            if (wakeReq)
            begin
               nxt_state = pss_pkg::ST_WAKE1;
            end
         end
         pss_pkg::ST_WAKE1:
         begin
            if (allGood)
            begin
               nxt_state = pss_pkg::ST_WAKE2;
            end
         end
         pss_pkg::ST_WAKE2:
         begin
            if (dwellDone && allGood)
            begin
               nxt_state = pss_pkg::ST_AWAKE_WAIT;
            end
         end
         pss_pkg::ST_AWAKE_WAIT:
         begin
            if (allGood)
            begin
               nxt_state = pss_pkg::ST_AWAKE;
            end
         end
         pss_pkg::ST_AWAKE:
         begin
            if (sleepReq_ff)
            begin
               nxt_state = pss_pkg::ST_PDOWN1;
            end
         end
         pss_pkg::ST_PDOWN1:
         begin
            if (dwellExact)
            begin
               nxt_state = pss_pkg::ST_PDOWN2;
            end
         end
         pss_pkg::ST_PDOWN2:
         begin
            if (dwellDone)
            begin
               nxt_state = pss_pkg::ST_ASLEEP;
            end
         end
         default: nxt_state = pss_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff <= pss_pkg::ST_RESET;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // outputs lag the state by one cycle so they come from flops
   pss_pkg::pss_supply_t supply_ff;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         supply_ff <= pss_pkg::SUP_OFF;
      end
      else
      begin
         supply_ff <= activeSup;
      end
   end

   assign supplyCtl = supply_ff;
   assign seqState = state_ff;
   assign prdata = rdata_ff;
   assign pready = ready_ff;
   assign pslverr = slverr_ff;
endmodule
`default_nettype wire

// *** test/pss_power_state_supply_config_assertions.sv ***
`default_nettype none
module pss_psc_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // regulator side
   input wire logic [3:0] pgoodPin,
   input wire logic wakePin,
   input wire pss_pkg::pss_supply_t supplyCtl,
   input wire pss_pkg::pss_state_t seqState
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   // ---------------------------------------------
   // shadow of the four registers, run length
   // ---------------------------------------------
   pss_pkg::pss_supply_t sh_ff [4];
   logic [4:0] dw_ff [4];
   pss_pkg::pss_state_t prevSt_ff;
   logic [31:0] runLen_ff;
   logic [1:0] wIdx;
   logic wHit;
   assign wIdx = 2'(paddr[5:2] - 4'h5);
   // control register index would alias onto the last shadow slot
   assign wHit = paddr == pss_pkg::ADDR_WAKE2 || paddr == pss_pkg::ADDR_RUN ||
                 paddr == pss_pkg::ADDR_PDOWN1 || paddr == pss_pkg::ADDR_PDOWN2;
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         sh_ff <= '{pss_pkg::SUP_WAKE2_RST, pss_pkg::SUP_RUN_RST,
                    pss_pkg::SUP_PDOWN1_RST, pss_pkg::SUP_PDOWN2_RST};
         dw_ff <= '{default: pss_pkg::DWELL_RST};
      end
      else if (psel && penable && pready && pwrite && !pslverr && wHit)
      begin
         sh_ff[wIdx] <= pss_pkg::pss_supply_t'({pwdata[14], pwdata[9:8], pwdata[5:4], 1'b1,
                                                pwdata[0]});
         dw_ff[wIdx] <= pwdata[20:16];
      end
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         prevSt_ff <= pss_pkg::ST_RESET;
         runLen_ff <= 32'h0000_0000;
      end
      else
      begin
         prevSt_ff <= seqState;
         runLen_ff <= (seqState != prevSt_ff) ? 32'h0000_0001 : runLen_ff + 32'h0000_0001;
      end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   a_wake2_supply: assert property (
      $past(seqState) == pss_pkg::ST_WAKE2 |-> supplyCtl == $past(sh_ff[0]))
      else $error("second wake outputs wrong");
   a_run_supply: assert property (
      $past(seqState) == pss_pkg::ST_AWAKE |-> supplyCtl == $past(sh_ff[1]))
      else $error("run outputs wrong");
   a_pdown1_supply: assert property (
      $past(seqState) == pss_pkg::ST_PDOWN1 |-> supplyCtl == $past(sh_ff[2]))
      else $error("first power-down outputs wrong");
   a_pdown2_supply: assert property (
      $past(seqState) == pss_pkg::ST_PDOWN2 |-> supplyCtl == $past(sh_ff[3]))
      else $error("second power-down outputs wrong");
   a_wake2_dwell: assert property (
      prevSt_ff == pss_pkg::ST_WAKE2 && seqState != pss_pkg::ST_WAKE2
      |-> runLen_ff >= (32'h0000_0001 << dw_ff[0])) else $error("second wake left early");
   a_pdown1_dwell: assert property (
      prevSt_ff == pss_pkg::ST_PDOWN1 && seqState != pss_pkg::ST_PDOWN1
      |-> runLen_ff == (32'h0000_0001 << dw_ff[2])) else $error("first power-down length");
   a_pdown2_dwell: assert property (
      prevSt_ff == pss_pkg::ST_PDOWN2 && seqState != pss_pkg::ST_PDOWN2
      |-> runLen_ff == (32'h0000_0001 << dw_ff[3])) else $error("second power-down length");
   a_state_order: assert property (
      seqState != $past(seqState) |-> seqState == (($past(seqState) == pss_pkg::ST_PDOWN2) ?
      pss_pkg::ST_ASLEEP : pss_pkg::pss_state_t'($past(seqState) + 3'h1)))
      else $error("state skipped");
   a_analog_on: assert property (
      seqState != pss_pkg::ST_RESET && $past(seqState) != pss_pkg::ST_RESET
      |-> supplyCtl.analogEn) else $error("analog buck off");
   a_ready_slot: assert property (
      psel && !penable |=> pready ##1 !pready) else $error("ready not one cycle");
endmodule
bind pss_power_state_supply_config pss_psc_checker chk_i (.mclk(mclk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pgoodPin(pgoodPin),
   .wakePin(wakePin), .supplyCtl(supplyCtl), .seqState(seqState));
`default_nettype wire

// *** test/pss_reg_model.sv ***
`default_nettype none
module pss_reg_model (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // supply controls and commanded faults
   input wire pss_pkg::pss_supply_t supplyCtl,
   input wire logic [3:0] stuckLow,
   // power good back
   output logic [3:0] pgoodPin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] en1_ff;
   logic [3:0] en2_ff;
   // good two cycles after enable, lost one cycle after disable
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         en1_ff <= 4'h0;
         en2_ff <= 4'h0;
      end
      else
      begin
         en1_ff <= {supplyCtl.ioEn, supplyCtl.pllEn, supplyCtl.analogEn, supplyCtl.coreEn};
         en2_ff <= en1_ff;
      end
   assign pgoodPin = en1_ff & en2_ff & ~stuckLow;
endmodule
`default_nettype wire

// *** test/pss_power_state_supply_config_tb_top.sv ***
`default_nettype none
module pss_power_state_supply_config_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic wakePin = 1'b0;
   logic [3:0] pgoodPin;
   logic [3:0] stuckLow = 4'h0;
   pss_pkg::pss_supply_t supplyCtl;
   pss_pkg::pss_state_t seqState;
   int errTotal = 0;
   int numChecks = 0;
   always #50 mclk = ~mclk;
   pss_power_state_supply_config DUT (.mclk(mclk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pgoodPin(pgoodPin), .wakePin(wakePin),
      .supplyCtl(supplyCtl), .seqState(seqState));
   pss_reg_model REG (.mclk(mclk), .resetn(resetn), .supplyCtl(supplyCtl),
      .stuckLow(stuckLow), .pgoodPin(pgoodPin));
   // ---------------------------------------------
   // checks and bus access
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      numChecks++;
      if (g !== x)
      begin
         errTotal++;
         $display("Error %s expected %h got %h", nm, x, g);
      end
   endtask
   task automatic chkSt(input pss_pkg::pss_state_t x);
      chk("state", 32'(x), 32'(seqState));
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk("apb ready", 32'h0000_0001, 32'(pready === 1'b1));
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk("read data", x, q);
      chk("read error", 32'(xe), 32'(e));
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
      chk("write error", 32'(xe), 32'(e));
   endtask
   function automatic logic [7:0] ra(input int i);
      return 8'(pss_pkg::ADDR_WAKE2 + 4 * i);
   endfunction
   function automatic logic [31:0] msk(input int i);
      return (i == pss_pkg::IDX_RUN) ? 32'h0000_4333 : 32'h001F_4333;
   endfunction
   function automatic pss_pkg::pss_supply_t sup(input logic [31:0] d);
      return pss_pkg::pss_supply_t'({d[14], d[9:8], d[5:4], 1'b1, d[0]});
   endfunction
   // ---------------------------------------------
   // sequencing
   // ---------------------------------------------
   task automatic visit(input pss_pkg::pss_state_t st, input logic [31:0] d, output int n);
      int w;
      w = 0;
      n = 0;
      while (seqState !== st && w < 400)
      begin
         @(posedge mclk);
         w++;
      end
      while (seqState === st && n < 4000)
      begin
         @(posedge mclk);
         n++;
         if (n == 1)
            chk("supply", 32'(sup(d)), 32'(supplyCtl));
      end
      chk("visit in time", 32'h0000_0001, 32'(w < 400 && n < 4000));
   endtask
   task automatic round(input logic [31:0] v [4], input int hold, input int lo, input int hi);
      int n;
      foreach (v[i])
      begin
         wr(ra(i), v[i], 1'b0);
         rd(ra(i), (v[i] & msk(i)) | 32'h0000_0002, 1'b0);
      end
      wakePin <= 1'b1;
      stuckLow <= (hold > 0) ? 4'h1 : 4'h0;
      fork
         visit(pss_pkg::ST_WAKE2, v[0], n);
         begin
            wait (seqState === pss_pkg::ST_WAKE2);
            repeat (hold) @(posedge mclk);
            stuckLow <= 4'h0;
         end
      join
      chk("wake2 cycles", 32'h0000_0001, 32'(n >= lo && n <= hi));
      wakePin <= 1'b0;
      visit(pss_pkg::ST_AWAKE_WAIT, v[1], n);
      visit(pss_pkg::ST_AWAKE, v[1], n);
      visit(pss_pkg::ST_PDOWN1, v[2], n);
      chk("pdown1 cycles", 32'h0000_0001 << v[2][20:16], 32'(n));
      visit(pss_pkg::ST_PDOWN2, v[3], n);
      chk("pdown2 cycles", 32'h0000_0001 << v[3][20:16], 32'(n));
      chkSt(pss_pkg::ST_ASLEEP);
   endtask
   task automatic finalReport();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      chkSt(pss_pkg::ST_ASLEEP);
      chk("asleep supply", 32'(pss_pkg::SUP_ASLEEP), 32'(supplyCtl));
      rd(8'h14, 32'h0010_0033, 1'b0);
      rd(8'h18, 32'h0000_0033, 1'b0);
      rd(8'h1c, 32'h0010_0022, 1'b0);
      rd(8'h20, 32'h0010_0002, 1'b0);
      rd(8'h30, 32'h0000_0000, 1'b1);
      wr(8'h30, 32'hFFFF_FFFF, 1'b1);
      rd(pss_pkg::ADDR_STAT, 32'h0000_0021, 1'b0);
      $display("test reset values done");
      for (int i = 0; i < pss_pkg::NUM_CFG; i++)
      begin
         wr(ra(i), 32'hFFFF_FFFF, 1'b0);
         rd(ra(i), msk(i), 1'b0);
         wr(ra(i), 32'h0000_0000, 1'b0);
         rd(ra(i), 32'h0000_0002, 1'b0);
      end
      $display("test field access done");
      wr(pss_pkg::ADDR_CTRL, 32'h0000_0001, 1'b0);
      rd(pss_pkg::ADDR_CTRL, 32'h0000_0001, 1'b0);
      round('{32'h0002_4123, 32'h0000_0233, 32'h0001_0302, 32'h0000_4010}, 30, 30, 40);
      $display("test power good hold done");
      round('{32'h0005_0212, 32'h0000_4121, 32'h0003_4030, 32'h0002_0221}, 0, 32, 33);
      $display("test long dwell done");
      finalReport();
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      errTotal++;
      $display("Error watchdog expected finish got timeout");
      finalReport();
   end
endmodule
`default_nettype wire
